// file: crf_pkg.sv
package crf_pkg;
  // ----------------------------------------------------------------
  // register indices and byte offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] IDX_GP0 = 4'h0;
  localparam logic [3:0] IDX_GP1 = 4'h1;
  localparam logic [3:0] IDX_GP2 = 4'h2;
  localparam logic [3:0] IDX_GP3 = 4'h3;
  localparam logic [3:0] IDX_PTR0 = 4'h4;
  localparam logic [3:0] IDX_PTR1 = 4'h5;
  localparam logic [3:0] IDX_FB = 4'h6;
  localparam logic [3:0] IDX_VTB = 4'h7;
  localparam logic [3:0] IDX_PC = 4'h8;
  localparam logic [3:0] IDX_USP = 4'h9;
  localparam logic [3:0] IDX_ISP = 4'ha;
  localparam logic [3:0] IDX_SB = 4'hb;
  localparam logic [3:0] IDX_FLG = 4'hc;
  localparam logic [3:0] IDX_LAST = 4'hc;
  localparam int ADDR_LSB = 2;
  localparam int ADDR_W = 8;
  // ----------------------------------------------------------------
  // flag register layout
  // ----------------------------------------------------------------
  localparam int FLG_W = 11;
  localparam int FLG_C = 0;
  localparam int FLG_D = 1;
  localparam int FLG_Z = 2;
  localparam int FLG_S = 3;
  localparam int FLG_B = 4;
  localparam int FLG_O = 5;
  localparam int FLG_U = 7;
  localparam logic [FLG_W-1:0] FLG_RESET = 11'h000;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [19:0] ADDR20_RESET = 20'h00000;
  // ----------------------------------------------------------------
  // datapath port selectors
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    CRF_SEL_GP0, CRF_SEL_GP1, CRF_SEL_GP2, CRF_SEL_GP3,
    CRF_SEL_GP0_HI, CRF_SEL_GP0_LO, CRF_SEL_GP1_HI, CRF_SEL_GP1_LO,
    CRF_SEL_PAIR_A, CRF_SEL_PAIR_B, CRF_SEL_PTR0, CRF_SEL_PTR1,
    CRF_SEL_PTR_PAIR, CRF_SEL_FB, CRF_SEL_SB, CRF_SEL_SP
  } crf_sel_t;

  typedef struct packed {
    logic we;
    crf_sel_t sel;
    logic [31:0] data;
  } crf_wr_t;

  typedef struct packed {
    logic valid;
    logic carry;
    logic ovf;
    logic [31:0] result;
    logic wide;
  } crf_alu_t;

  typedef struct packed {
    logic [15:0] gp0;
    logic [15:0] gp1;
    logic [15:0] gp2;
    logic [15:0] gp3;
    logic [15:0] ptr0;
    logic [15:0] ptr1;
    logic [15:0] fb;
  } crf_bank_t;
endpackage

// file: crf_flag_unit.sv
`timescale 1ns/1ps
`default_nettype none
module crf_flag_unit
  import crf_pkg::*;
(
  input wire crf_pkg::crf_alu_t alu_i,
  input wire logic [crf_pkg::FLG_W-1:0] flg_i,
  output logic [crf_pkg::FLG_W-1:0] flg_o
);
  import crf_pkg::*;
  logic zero_w;
  logic neg_w;
  always_comb begin
    zero_w = alu_i.wide ? (alu_i.result == 32'h0000_0000) : (alu_i.result[15:0] == 16'h0000);
    neg_w = alu_i.wide ? alu_i.result[31] : alu_i.result[15];
    flg_o = flg_i;
    if (alu_i.valid) begin
      flg_o[FLG_C] = alu_i.carry;
      flg_o[FLG_Z] = zero_w;
      flg_o[FLG_S] = neg_w;
      flg_o[FLG_O] = alu_i.ovf;
    end
  end
endmodule
`default_nettype wire

// file: crf_regfile.sv
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - four 16-bit general data registers
// - first two split into byte halves
// - third joins first, fourth joins second
// - two 16-bit address registers as operands
// - address registers join as 32 bits
// - 16-bit frame-base register
// - 20-bit vector-table base register
// - 20-bit program counter
// - user and interrupt stack pointers
// - 16-bit static-base register
// - 11-bit flag register of status
// - carry flag captures alu carry out
// - zero flag set on zero result
// - sign flag set on negative result
// - bank flag selects register bank
// - overflow flag set on overflow
module crf_regfile
  import crf_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [crf_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire crf_pkg::crf_wr_t dp_wr_i,
  input wire crf_pkg::crf_alu_t dp_alu_i,
  input wire crf_pkg::crf_sel_t dp_rd_sel_i,
  input wire logic pc_load_i,
  input wire logic [19:0] pc_next_i,
  output logic [31:0] dp_rd_data_o,
  output logic [19:0] pc_o,
  output logic [19:0] vtb_o,
  output logic [15:0] sp_o,
  output logic [15:0] fb_o,
  output logic [15:0] sb_o,
  output logic [crf_pkg::FLG_W-1:0] flg_o
);
  import crf_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    crf_bank_t [1:0] bank;
    logic [19:0] vtb;
    logic [19:0] pc;
    logic [15:0] user_stack_ptr;
    logic [15:0] int_stack_ptr;
    logic [15:0] sb;
    logic [FLG_W-1:0] cpu_flags;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [31:0] rd_data;
  } crf_state_t;

  crf_state_t st_reg;
  crf_state_t st_next;
  logic [FLG_W-1:0] flg_alu_w;

  crf_flag_unit u_flags (
    .alu_i(dp_alu_i),
    .flg_i(st_reg.cpu_flags),
    .flg_o(flg_alu_w)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic idx_ok(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-ADDR_LSB-1:0] i;
    i = a[ADDR_W-1:ADDR_LSB];
    idx_ok = (a[ADDR_LSB-1:0] == '0) && (i <= (ADDR_W-ADDR_LSB)'(IDX_LAST));
  endfunction

  // read mux for the datapath port; bus reads use their own case
  function automatic logic [31:0] dp_read(input crf_state_t s, input crf_sel_t sel);
    crf_bank_t b;
    logic [15:0] sp;
    b = s.bank[s.cpu_flags[FLG_B]];
    sp = s.cpu_flags[FLG_U] ? s.user_stack_ptr : s.int_stack_ptr;
    dp_read = 32'h0000_0000;
    unique case (sel)
      CRF_SEL_GP0: dp_read = {16'h0000, b.gp0};
      CRF_SEL_GP1: dp_read = {16'h0000, b.gp1};
      CRF_SEL_GP2: dp_read = {16'h0000, b.gp2};
      CRF_SEL_GP3: dp_read = {16'h0000, b.gp3};
      CRF_SEL_GP0_HI: dp_read = {24'h000000, b.gp0[15:8]};
      CRF_SEL_GP0_LO: dp_read = {24'h000000, b.gp0[7:0]};
      CRF_SEL_GP1_HI: dp_read = {24'h000000, b.gp1[15:8]};
      CRF_SEL_GP1_LO: dp_read = {24'h000000, b.gp1[7:0]};
      CRF_SEL_PAIR_A: dp_read = {b.gp2, b.gp0};
      CRF_SEL_PAIR_B: dp_read = {b.gp3, b.gp1};
      CRF_SEL_PTR0: dp_read = {16'h0000, b.ptr0};
      CRF_SEL_PTR1: dp_read = {16'h0000, b.ptr1};
      CRF_SEL_PTR_PAIR: dp_read = {b.ptr1, b.ptr0};
      CRF_SEL_FB: dp_read = {16'h0000, b.fb};
      CRF_SEL_SB: dp_read = {16'h0000, s.sb};
      CRF_SEL_SP: dp_read = {16'h0000, sp};
    endcase
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic bsel;
    logic [3:0] idx;
    logic acc;
    crf_bank_t b;
    bsel = 1'b0;
    idx = 4'h0;
    acc = 1'b0;
    b = '0;
    st_next = st_reg;
    // datapath write, bank chosen by the current flag
    bsel = st_reg.cpu_flags[FLG_B];
    b = st_reg.bank[bsel];
    if (dp_wr_i.we) begin
      unique case (dp_wr_i.sel)
        CRF_SEL_GP0: b.gp0 = dp_wr_i.data[15:0];
        CRF_SEL_GP1: b.gp1 = dp_wr_i.data[15:0];
        CRF_SEL_GP2: b.gp2 = dp_wr_i.data[15:0];
        CRF_SEL_GP3: b.gp3 = dp_wr_i.data[15:0];
        CRF_SEL_GP0_HI: b.gp0[15:8] = dp_wr_i.data[7:0];
        CRF_SEL_GP0_LO: b.gp0[7:0] = dp_wr_i.data[7:0];
        CRF_SEL_GP1_HI: b.gp1[15:8] = dp_wr_i.data[7:0];
        CRF_SEL_GP1_LO: b.gp1[7:0] = dp_wr_i.data[7:0];
        CRF_SEL_PAIR_A: {b.gp2, b.gp0} = dp_wr_i.data;
        CRF_SEL_PAIR_B: {b.gp3, b.gp1} = dp_wr_i.data;
        CRF_SEL_PTR0: b.ptr0 = dp_wr_i.data[15:0];
        CRF_SEL_PTR1: b.ptr1 = dp_wr_i.data[15:0];
        CRF_SEL_PTR_PAIR: {b.ptr1, b.ptr0} = dp_wr_i.data;
        CRF_SEL_FB: b.fb = dp_wr_i.data[15:0];
        CRF_SEL_SB: st_next.sb = dp_wr_i.data[15:0];
        CRF_SEL_SP: begin
          if (st_reg.cpu_flags[FLG_U]) begin
            st_next.user_stack_ptr = dp_wr_i.data[15:0];
          end else begin
            st_next.int_stack_ptr = dp_wr_i.data[15:0];
          end
        end
      endcase
    end
    st_next.bank[bsel] = b;
    if (pc_load_i) begin
      st_next.pc = pc_next_i;
    end
    st_next.cpu_flags = flg_alu_w;
    st_next.rd_data = dp_read(st_reg, dp_rd_sel_i);

    // apb slave: one wait state per access phase, bus write wins over core
    st_next.pready = 1'b0;
    st_next.pslverr = 1'b0;
    acc = psel_i && penable_i && !st_reg.pready;
    idx = paddr_i[ADDR_LSB+3:ADDR_LSB];
    if (acc) begin
      st_next.pready = 1'b1;
      st_next.pslverr = !idx_ok(paddr_i);
      st_next.prdata = 32'h0000_0000;
      if (idx_ok(paddr_i)) begin
        b = st_next.bank[bsel];
        if (pwrite_i) begin
          unique case (idx)
            IDX_GP0: b.gp0 = pwdata_i[15:0];
            IDX_GP1: b.gp1 = pwdata_i[15:0];
            IDX_GP2: b.gp2 = pwdata_i[15:0];
            IDX_GP3: b.gp3 = pwdata_i[15:0];
            IDX_PTR0: b.ptr0 = pwdata_i[15:0];
            IDX_PTR1: b.ptr1 = pwdata_i[15:0];
            IDX_FB: b.fb = pwdata_i[15:0];
            IDX_VTB: st_next.vtb = pwdata_i[19:0];
            IDX_PC: st_next.pc = pwdata_i[19:0];
            IDX_USP: st_next.user_stack_ptr = pwdata_i[15:0];
            IDX_ISP: st_next.int_stack_ptr = pwdata_i[15:0];
            IDX_SB: st_next.sb = pwdata_i[15:0];
            IDX_FLG: st_next.cpu_flags = pwdata_i[FLG_W-1:0];
            default: ;
          endcase
          st_next.bank[bsel] = b;
        end else begin
          b = st_reg.bank[bsel];
          unique case (idx)
            IDX_GP0: st_next.prdata = {16'h0000, b.gp0};
            IDX_GP1: st_next.prdata = {16'h0000, b.gp1};
            IDX_GP2: st_next.prdata = {16'h0000, b.gp2};
            IDX_GP3: st_next.prdata = {16'h0000, b.gp3};
            IDX_PTR0: st_next.prdata = {16'h0000, b.ptr0};
            IDX_PTR1: st_next.prdata = {16'h0000, b.ptr1};
            IDX_FB: st_next.prdata = {16'h0000, b.fb};
            IDX_VTB: st_next.prdata = {12'h000, st_reg.vtb};
            IDX_PC: st_next.prdata = {12'h000, st_reg.pc};
            IDX_USP: st_next.prdata = {16'h0000, st_reg.user_stack_ptr};
            IDX_ISP: st_next.prdata = {16'h0000, st_reg.int_stack_ptr};
            IDX_SB: st_next.prdata = {16'h0000, st_reg.sb};
            IDX_FLG: st_next.prdata = {21'h000000, st_reg.cpu_flags};
            default: st_next.prdata = 32'h0000_0000;
          endcase
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_reg <= '0;
      st_reg.cpu_flags <= FLG_RESET;
      st_reg.pc <= ADDR20_RESET;
      st_reg.vtb <= ADDR20_RESET;
      st_reg.user_stack_ptr <= WORD_RESET;
      st_reg.int_stack_ptr <= WORD_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all from flops
  // ----------------------------------------------------------------
  always_comb begin
    prdata_o = st_reg.prdata;
    pready_o = st_reg.pready;
    pslverr_o = st_reg.pslverr;
    dp_rd_data_o = st_reg.rd_data;
    pc_o = st_reg.pc;
    vtb_o = st_reg.vtb;
    // debug flag passed as stored; software is expected to keep it 0
    flg_o = st_reg.cpu_flags;
    fb_o = st_reg.bank[st_reg.cpu_flags[FLG_B]].fb;
    sb_o = st_reg.sb;
    sp_o = st_reg.cpu_flags[FLG_U] ? st_reg.user_stack_ptr : st_reg.int_stack_ptr;
  end
endmodule
`default_nettype wire

// file: crf_regfile_sva.sv
`timescale 1ns/1ps
`default_nettype none
module crf_regfile_sva
  import crf_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic [crf_pkg::ADDR_W-1:0] paddr_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire crf_pkg::crf_alu_t dp_alu_i,
  input wire logic pc_load_i,
  input wire logic [19:0] pc_next_i,
  input wire logic [19:0] pc_o,
  input wire logic [crf_pkg::FLG_W-1:0] flg_o
);
  // --
  // bus timing, pc and flags
  // --
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  sequence s_acc;
    psel_i && penable_i && !pready_o;
  endsequence
  // bus write wins, so flag checks skip bus cycles
  sequence s_alu;
    dp_alu_i.valid && !psel_i;
  endsequence
  a_one_wait: assert property (s_acc |=> pready_o)
    else $error("access unanswered");
  a_err_ready: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  a_err_map: assert property (s_acc ##0 (paddr_i[5:2] > 4'hc || paddr_i[1:0] != 2'h0)
    |=> pslverr_o) else $error("bad address taken");
  a_pc_load: assert property (pc_load_i && !psel_i |=> pc_o == $past(pc_next_i))
    else $error("pc not loaded");
  a_carry_take: assert property (s_alu |=> flg_o[FLG_C] == $past(dp_alu_i.carry))
    else $error("carry wrong");
  a_ovf_take: assert property (s_alu |=> flg_o[FLG_O] == $past(dp_alu_i.ovf))
    else $error("overflow wrong");
  a_zero_flag: assert property (s_alu |=> flg_o[FLG_Z] == ($past(dp_alu_i.wide) ?
    $past(dp_alu_i.result) == 32'h0 : $past(dp_alu_i.result[15:0]) == 16'h0))
    else $error("zero wrong");
  a_sign_flag: assert property (s_alu |=> flg_o[FLG_S] == ($past(dp_alu_i.wide) ?
    $past(dp_alu_i.result[31]) : $past(dp_alu_i.result[15]))) else $error("sign wrong");
endmodule
bind crf_regfile crf_regfile_sva crf_regfile_sva_inst (.clk_i, .rstn_i, .psel_i, .penable_i,
  .paddr_i, .pready_o, .pslverr_o, .dp_alu_i, .pc_load_i, .pc_next_i, .pc_o, .flg_o);
`default_nettype wire

// file: crf_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module crf_core_model
  import crf_pkg::*;
(
  input wire logic clk_i,
  input wire logic [31:0] rd_data_i,
  output crf_pkg::crf_wr_t wr_o,
  output crf_pkg::crf_alu_t alu_o,
  output crf_pkg::crf_sel_t sel_o,
  output logic pc_load_o,
  output logic [19:0] pc_next_o
);
  // --
  // datapath stand-in
  // --
  initial begin
    wr_o = '0;
    alu_o = '0;
    sel_o = CRF_SEL_GP0;
    pc_load_o = 1'h0;
    pc_next_o = 20'h0;
  end
  // released data is inverted so stale values never pass
  task automatic put(input crf_sel_t s, input logic [31:0] d);
    @(posedge clk_i);
    wr_o <= '{1'h1, s, d};
    @(posedge clk_i);
    wr_o <= '{1'h0, s, ~d};
  endtask
  task automatic alu(input logic c, o, w, input logic [31:0] r);
    @(posedge clk_i);
    alu_o <= '{1'h1, c, o, r, w};
    @(posedge clk_i);
    alu_o <= '{1'h0, c, o, ~r, w};
  endtask
  task automatic get(input crf_sel_t s, output logic [31:0] d);
    @(posedge clk_i);
    sel_o <= s;
    @(posedge clk_i);
    #1;
    d = rd_data_i;
  endtask
  task automatic jump(input logic [19:0] a);
    @(posedge clk_i);
    pc_load_o <= 1'h1;
    pc_next_o <= a;
    @(posedge clk_i);
    pc_load_o <= 1'h0;
    pc_next_o <= ~a;
  endtask
endmodule
`default_nettype wire

// file: crf_regfile_tb.sv
`timescale 1ns/1ps
`default_nettype none
module crf_regfile_tb;
  import crf_pkg::*;
  logic clk = 1'h0;
  logic rstn = 1'h0;
  logic psel = 1'h0;
  logic pen = 1'h0;
  logic pwr = 1'h0;
  logic [7:0] pa = 8'h0;
  logic [31:0] pwd = 32'h0;
  logic [31:0] prd, rd, q;
  logic rdy, err, perr, ld;
  logic [19:0] pc, vtb, nx;
  logic [15:0] sp, fb, sb;
  logic [10:0] cpu_flags;
  crf_wr_t wr;
  crf_alu_t alu;
  crf_sel_t sel;
  int fails = 0;
  int check_count = 0;
  int cyc = 0;
  always #20 clk = ~clk;
  crf_regfile crf_regfile_inst (.clk_i(clk), .rstn_i(rstn), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd), .pready_o(rdy),
    .pslverr_o(err), .dp_wr_i(wr), .dp_alu_i(alu), .dp_rd_sel_i(sel), .pc_load_i(ld),
    .pc_next_i(nx), .dp_rd_data_o(rd), .pc_o(pc), .vtb_o(vtb), .sp_o(sp), .fb_o(fb),
    .sb_o(sb), .flg_o(cpu_flags));
  crf_core_model crf_core_model_inst (.clk_i(clk), .rd_data_i(rd), .wr_o(wr),
    .alu_o(alu), .sel_o(sel), .pc_load_o(ld), .pc_next_o(nx));
  // --
  // helpers and scenarios
  // --
  task automatic chk(input logic [31:0] s, e);
    check_count++;
    if (s !== e) begin
      fails++;
      $display("mismatch %0t got %h want %h", $time, s, e);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'h1;
    do @(posedge clk); while (rdy !== 1'h1);
    q = prd;
    perr = err;
    psel <= 1'h0;
    pen <= 1'h0;
  endtask
  function automatic logic [31:0] pat(int i);
    logic [31:0] m;
    m = (i == 7 || i == 8) ? 32'hfffff : 32'hffff;
    return (32'h2c3b4a59 + 32'h01010101 * i) & m;
  endfunction
  task automatic t_regs;
    for (int i = 0; i < 13; i++) begin
      bus(1'h0, 8'(i * 4), 32'h0);
      chk(q, 32'h0);
    end
    for (int i = 0; i < 12; i++) bus(1'h1, 8'(i * 4), pat(i));
    for (int i = 0; i < 12; i++) begin
      bus(1'h0, 8'(i * 4), 32'h0);
      chk(q, pat(i));
    end
    chk({12'h0, pc}, pat(8));
    chk({12'h0, vtb}, pat(7));
    chk({16'h0, fb}, pat(6));
    chk({16'h0, sb}, pat(11));
    chk({16'h0, sp}, pat(10));
    bus(1'h1, 8'h30, 32'h80);
    chk({16'h0, sp}, pat(9));
    bus(1'h1, 8'h30, 32'h0);
    bus(1'h1, 8'h34, 32'h1);
    chk({31'h0, perr}, 32'h1);
    chk(q, 32'h0);
    bus(1'h0, 8'h02, 32'h0);
    chk({31'h0, perr}, 32'h1);
    $display("regs done");
  endtask
  task automatic t_views;
    crf_core_model_inst.get(CRF_SEL_GP0_HI, q);
    chk(q, 32'h4a);
    crf_core_model_inst.get(CRF_SEL_GP1_LO, q);
    chk(q, 32'h5a);
    crf_core_model_inst.get(CRF_SEL_PAIR_A, q);
    chk(q, 32'h4c5b4a59);
    crf_core_model_inst.get(CRF_SEL_PAIR_B, q);
    chk(q, 32'h4d5c4b5a);
    crf_core_model_inst.get(CRF_SEL_PTR_PAIR, q);
    chk(q, 32'h4f5e4e5d);
    crf_core_model_inst.put(CRF_SEL_GP0_HI, 32'hab);
    bus(1'h0, 8'h0, 32'h0);
    chk(q, 32'hab59);
    $display("views done");
  endtask
  task automatic t_alu;
    logic [34:0] tab [4];
    logic z, s;
    tab = '{{3'h4, 32'h10000}, {3'h2, 32'h8000}, {3'h1, 32'h0}, {3'h1, 32'h80000000}};
    foreach (tab[i]) begin
      crf_core_model_inst.alu(tab[i][34], tab[i][33], tab[i][32], tab[i][31:0]);
      z = tab[i][32] ? tab[i][31:0] == 32'h0 : tab[i][15:0] == 16'h0;
      s = tab[i][32] ? tab[i][31] : tab[i][15];
      #1;
      chk({21'h0, cpu_flags & 11'h2d}, {26'h0, tab[i][33], 1'h0, s, z, 1'h0, tab[i][34]});
    end
    $display("alu done");
  endtask
  task automatic t_bank;
    bus(1'h1, 8'h0, 32'haaaa);
    bus(1'h1, 8'h30, 32'h10);
    bus(1'h1, 8'h0, 32'h5555);
    bus(1'h0, 8'h0, 32'h0);
    chk(q, 32'h5555);
    bus(1'h1, 8'h30, 32'h0);
    bus(1'h0, 8'h0, 32'h0);
    chk(q, 32'haaaa);
    crf_core_model_inst.jump(20'habcde);
    #1;
    chk({12'h0, pc}, 32'habcde);
    $display("bank done");
  endtask
  task automatic final_report;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'h1;
    t_regs;
    t_views;
    t_alu;
    t_bank;
    final_report;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      final_report;
    end
  end
endmodule
`default_nettype wire
